//--- core/fsq_host.sv
/*
  host-side sequencer for a multi-bank nor flash: takes orders over an ahb-lite
  slave and plays the documented write-cycle sequences on the flash pins.
  assumes flash inputs are synchronous to hclk and one ahb master.
*/
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
// What this block does
// - secure region entered by three, left by four
// - program is two unlocks, set-up, address/data
// - hardware reset aborts; reissue after read mode
// - unlock bypass: two unlocks then 20h
// - bypass program is A0h then address/data
// - bypass exit is bank 90h then 00h
// - accel voltage only during accelerated programming
// - chip erase is six cycles ending 10h
// - sector erase six cycles, sector address, 30h
// - more sectors only within 80 us window
// - suspend B0h only for sector erase
`timescale 1ns/100ps
module fsq_host
  import fsq_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output fsq_pkg::fsq_pins_t     flash_pins,
  input  wire logic [15:0]       flash_dq_i,
  input  wire logic              ready_busy_n
);
  import fsq_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_WR_LOW, S_WR_HIGH, S_RD, S_SETTLE, S_ACC_WAIT,
    S_RST_LOW, S_RST_REC} fsq_state_t;

  // bus-side state
  logic        ap_wr_q,  ap_wr_d;       // write pending for data phase
  logic [7:0]  ap_ofs_q, ap_ofs_d;      // latched word offset
  logic [31:0] ctrl_q,   ctrl_d;        // last order
  logic [21:0] addr_q,   addr_d;        // target address
  logic [15:0] wdata_q,  wdata_d;       // program data
  logic        go_q,     go_d;          // one-cycle launch pulse
  logic        eclr_q,   eclr_d;        // error clear pulse
  logic [31:0] rdata_q,  rdata_d;       // hrdata flop

  // sequencer state
  fsq_state_t  st_q,   st_d;
  fsq_cmd_t    cmd_q,  cmd_d;
  logic [2:0]  idx_q,  idx_d;           // step within sequence
  logic [11:0] cnt_q,  cnt_d;           // phase timer
  logic [11:0] win_q,  win_d;           // sector-erase window timer
  fsq_op_t     op_q,   op_d;            // operation the flash runs
  logic        byp_q,  byp_d;           // bank in unlock bypass
  logic        sec_q,  sec_d;           // secure region mapped
  logic        err_q,  err_d;           // sticky refused-order flag
  logic [15:0] rd_q,   rd_d;            // last word read from flash
  fsq_pins_t   pins_q, pins_d;

  fsq_cmd_t    ord;                     // order in ctrl register
  fsq_step_t   stp;                     // current step's cycle
  logic        legal;                   // order may go now
  logic [31:0] status;

  assign ord = fsq_cmd_t'(ctrl_q[3:0]);

  // true when the decoded phase count has elapsed
  function automatic logic done_at(logic [11:0] c, int n);
    return c == 12'(n - 1);
  endfunction : done_at

  // status word from live state
  always_comb begin
    status = '0;
    status[ST_CTL_BUSY] = (st_q != S_IDLE);
    status[ST_RDY] = ready_busy_n;
    status[ST_BYP] = byp_q;
    status[ST_SEC] = sec_q;
    status[ST_WIN] = (win_q != 12'h000);
    status[ST_ERR] = err_q;
    status[ST_ACC] = pins_q.accel_hv_en;
    status[ST_OP_LSB +: 2] = op_q;
    status[ST_RD_LSB +: 16] = rd_q;
  end

  // ahb-lite slave: zero wait states, read data prepared in the address phase
  always_comb begin
    ap_wr_d  = 1'b0;
    ap_ofs_d = ap_ofs_q;
    ctrl_d   = ctrl_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    go_d     = 1'b0;
    eclr_d   = 1'b0;
    rdata_d  = rdata_q;
    if (ap_wr_q) begin
      case (ap_ofs_q)
        OFS_CTRL: begin
          ctrl_d = hwdata;
          go_d   = 1'b1;
        end
        OFS_ADDR:   addr_d  = hwdata[21:0];
        OFS_WDATA:  wdata_d = hwdata[15:0];
        OFS_STATUS: eclr_d  = hwdata[ST_ERR];
        default:    ;                   // unmapped writes are dropped
      endcase
    end
    if (hsel && htrans[1] && hready) begin
      ap_wr_d  = hwrite;
      ap_ofs_d = {haddr[7:2], 2'b00};   // hsize ignored: word access only
      case ({haddr[7:2], 2'b00})
        OFS_CTRL:   rdata_d = ctrl_q;
        OFS_ADDR:   rdata_d = {10'h000, addr_q};
        OFS_WDATA:  rdata_d = {16'h0000, wdata_q};
        OFS_STATUS: rdata_d = status;
        default:    rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q  <= 1'b0;
      ap_ofs_q <= 8'h00;
      ctrl_q   <= CTRL_RST;
      addr_q   <= 22'h00_0000;
      wdata_q  <= 16'h0000;
      go_q     <= 1'b0;
      eclr_q   <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      ap_wr_q  <= ap_wr_d;
      ap_ofs_q <= ap_ofs_d;
      ctrl_q   <= ctrl_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      go_q     <= go_d;
      eclr_q   <= eclr_d;
      rdata_q  <= rdata_d;
    end
  end

  // the host keeps the device's ignore rules by refusing instead of sending
  always_comb begin
    logic busy;
    logic win;
    logic byp;
    busy = !ready_busy_n;
    win  = (win_q != 12'h000);
    byp  = byp_q | ctrl_q[CT_ACC];
    case (ord)
      C_HW_RESET, C_READ: legal = 1'b1;
      C_SUSPEND:   legal = (op_q == OP_SECT) && (win || busy);
      C_SECT_ADD:  legal = (op_q == OP_SECT) && win;
      C_BYP_PROG:  legal = byp && !busy;
      C_BYP_EXIT:  legal = byp_q && !busy;
      C_SEC_ENTER: legal = !byp && !busy && !win;
      default:     legal = !byp && (!busy || win);
    endcase
  end

  assign stp = fsq_step(cmd_q, idx_q, pins_q.byte_word_select, addr_q, wdata_q);

  // sequencer: plays write cycles, reads, and the hardware reset pulse
  always_comb begin
    fsq_step_t s0;
    fsq_step_t s1;                      // next step of the running sequence
    s0     = fsq_step(ord, 3'd0, ctrl_q[CT_BW], addr_q, wdata_q);
    s1     = fsq_step(cmd_q, idx_q + 3'd1, pins_q.byte_word_select, addr_q, wdata_q);
    st_d   = st_q;
    cmd_d  = cmd_q;
    idx_d  = idx_q;
    cnt_d  = cnt_q + 12'h001;
    win_d  = (win_q != 12'h000) ? win_q - 12'h001 : win_q;
    op_d   = op_q;
    byp_d  = byp_q;
    sec_d  = sec_q;
    err_d  = err_q & ~eclr_q;
    rd_d   = rd_q;
    pins_d = pins_q;
    // the flash ends its own algorithm; host only watches ready_busy_n
    if (st_q == S_IDLE && ready_busy_n && win_q == 12'h000) op_d = OP_NONE;
    case (st_q)
      S_IDLE: begin
        if (go_q && legal) begin
          cmd_d = ord;
          idx_d = 3'd0;
          cnt_d = 12'h000;
          pins_d.byte_word_select = ctrl_q[CT_BW];
          if (ord != C_SECT_ADD && ord != C_SUSPEND && ord != C_READ && ord != C_HW_RESET
              && win_q != 12'h000) begin
            win_d = 12'h000;
            op_d  = OP_NONE;
          end
          if (ord == C_HW_RESET) begin
            pins_d.reset_n = 1'b0;
            pins_d.accel_hv_en = 1'b0;
            st_d = S_RST_LOW;
          end else if (ord == C_READ) begin
            pins_d.addr  = addr_q;
            pins_d.dq_oe = 1'b0;
            pins_d.ce_n  = 1'b0;
            pins_d.oe_n  = 1'b0;
            st_d = S_RD;
          end else begin
            pins_d.addr  = s0.addr;
            pins_d.dq    = s0.data;
            pins_d.dq_oe = 1'b1;
            pins_d.ce_n  = 1'b0;
            pins_d.we_n  = 1'b0;
            pins_d.accel_hv_en = (ord == C_BYP_PROG) && ctrl_q[CT_ACC];
            if (ord == C_SUSPEND) win_d = 12'h000;
            st_d = S_WR_LOW;
          end
        end else if (go_q) begin
          err_d = 1'b1;                 // refused order; set wins over clear
        end
      end
      S_WR_LOW: begin
        if (done_at(cnt_q, WP_CYC)) begin
          pins_d.we_n = 1'b1;           // data latched on this rising edge
          pins_d.ce_n = 1'b1;
          cnt_d = 12'h000;
          st_d  = S_WR_HIGH;
        end
      end
      S_WR_HIGH: begin
        if (done_at(cnt_q, WPH_CYC)) begin
          cnt_d = 12'h000;
          if (!stp.last) begin
            idx_d = idx_q + 3'd1;
            pins_d.addr = s1.addr;
            pins_d.dq   = s1.data;
            pins_d.ce_n = 1'b0;
            pins_d.we_n = 1'b0;
            st_d = S_WR_LOW;
          end else begin
            pins_d.dq_oe = 1'b0;
            st_d = S_IDLE;
            case (cmd_q)
              C_PROG, C_BYP_PROG: begin
                op_d = OP_PROG;
                st_d = S_SETTLE;
              end
              C_CHIP_ERASE: begin
                op_d = OP_CHIP;
                st_d = S_SETTLE;
              end
              C_SECT_ERASE, C_SECT_ADD: begin
                op_d  = OP_SECT;
                win_d = 12'(WIN_CYC);
                st_d  = S_SETTLE;
              end
              C_SUSPEND:   op_d  = OP_NONE;
              C_BYP_ENTER: byp_d = 1'b1;
              C_BYP_EXIT:  byp_d = 1'b0;
              C_SEC_ENTER: sec_d = 1'b1;
              C_SEC_EXIT:  sec_d = 1'b0;
              C_RESET:     op_d  = OP_NONE;
              default:     ;
            endcase
          end
        end
      end
      S_SETTLE: begin
        // ready_busy_n is not valid until the device has had time to drop it
        if (done_at(cnt_q, BUSY_CYC)) st_d = pins_q.accel_hv_en ? S_ACC_WAIT : S_IDLE;
      end
      S_ACC_WAIT: begin
        if (ready_busy_n) begin
          pins_d.accel_hv_en = 1'b0;
          st_d = S_IDLE;
        end
      end
      S_RD: begin
        if (done_at(cnt_q, ACC_CYC)) begin
          rd_d = flash_dq_i;            // array data or polling/toggle bits
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
          st_d = S_IDLE;
        end
      end
      S_RST_LOW: begin
        if (done_at(cnt_q, RP_CYC)) begin
          pins_d.reset_n = 1'b1;
          cnt_d = 12'h000;
          st_d  = S_RST_REC;
        end
      end
      S_RST_REC: begin
        if (done_at(cnt_q, RH_CYC)) begin
          op_d  = OP_NONE;
          win_d = 12'h000;
          byp_d = 1'b0;
          sec_d = 1'b0;
          st_d  = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q   <= S_IDLE;
      cmd_q  <= C_READ;
      idx_q  <= 3'd0;
      cnt_q  <= 12'h000;
      win_q  <= 12'h000;
      op_q   <= OP_NONE;
      byp_q  <= 1'b0;
      sec_q  <= 1'b0;
      err_q  <= 1'b0;
      rd_q   <= 16'h0000;
      pins_q <= PINS_RST;
    end else begin
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      idx_q  <= idx_d;
      cnt_q  <= cnt_d;
      win_q  <= win_d;
      op_q   <= op_d;
      byp_q  <= byp_d;
      sec_q  <= sec_d;
      err_q  <= err_d;
      rd_q   <= rd_d;
      pins_q <= pins_d;
    end
  end

  assign flash_pins = pins_q;
  assign hrdata     = rdata_q;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
endmodule : fsq_host

//--- inc/fsq_pkg.sv
/*
  constants, types and the command-sequence table of the flash sequencer host.
  assumes a 40 MHz hclk and a 16-bit flash data bus with 22 address pins.
*/
package fsq_pkg;
  // clock and timing, each time in its own unit
  localparam int CLK_MHZ     = 40;
  localparam int T_WP_NS     = 35;    // write strobe low, least
  localparam int T_WPH_NS    = 30;    // write strobe high, least
  localparam int T_ACC_NS    = 70;    // read access, least
  localparam int T_RP_NS     = 500;   // hardware reset pulse, least
  localparam int T_RH_NS     = 50;    // recovery after reset, least
  localparam int T_BUSY_NS   = 90;    // strobe to ready_busy_n low, least
  localparam int T_SE_WIN_US = 80;    // sector-erase wait window, longest
  localparam int WP_CYC   = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPH_CYC  = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC  = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC   = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int RH_CYC   = (T_RH_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_CYC = (T_BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int WIN_CYC  = T_SE_WIN_US * CLK_MHZ;
  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0100;
  // field positions
  localparam int CT_BW = 8;
  localparam int CT_ACC = 9;
  localparam int ST_CTL_BUSY = 0;
  localparam int ST_RDY = 1;
  localparam int ST_BYP = 2;
  localparam int ST_SEC = 3;
  localparam int ST_WIN = 4;
  localparam int ST_ERR = 5;
  localparam int ST_ACC = 6;
  localparam int ST_OP_LSB = 8;
  localparam int ST_RD_LSB = 16;
  // unlock addresses in word and byte mode
  localparam logic [21:0] UA1_W = 22'h00_0555;
  localparam logic [21:0] UA2_W = 22'h00_02AA;
  localparam logic [21:0] UA1_B = 22'h00_0AAA;
  localparam logic [21:0] UA2_B = 22'h00_0555;
  // command data codes
  localparam logic [15:0] D_UNL1 = 16'h00AA;
  localparam logic [15:0] D_UNL2 = 16'h0055;
  localparam logic [15:0] D_PROG = 16'h00A0;
  localparam logic [15:0] D_ERASE = 16'h0080;
  localparam logic [15:0] D_CHIP = 16'h0010;
  localparam logic [15:0] D_SECT = 16'h0030;
  localparam logic [15:0] D_BYP = 16'h0020;
  localparam logic [15:0] D_X90 = 16'h0090;
  localparam logic [15:0] D_X00 = 16'h0000;
  localparam logic [15:0] D_RESET = 16'h00F0;
  localparam logic [15:0] D_SUSP = 16'h00B0;
  localparam logic [15:0] D_SEC_IN = 16'h0088;

  typedef enum logic [3:0] {C_READ, C_RESET, C_PROG, C_BYP_ENTER, C_BYP_PROG, C_BYP_EXIT,
    C_CHIP_ERASE, C_SECT_ERASE, C_SECT_ADD, C_SUSPEND, C_SEC_ENTER, C_SEC_EXIT,
    C_HW_RESET} fsq_cmd_t;
  typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_CHIP, OP_SECT} fsq_op_t;

  // flash-side pins, all driven from flops
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] dq;
    logic        dq_oe;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        reset_n;
    logic        byte_word_select;
    logic        accel_hv_en;
  } fsq_pins_t;
  localparam fsq_pins_t PINS_RST = '{addr: '0, dq: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1,
    oe_n: 1'b1, reset_n: 1'b1, byte_word_select: 1'b1, accel_hv_en: 1'b0};

  // one write cycle of a sequence
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
    logic        last;
  } fsq_step_t;

  // step idx of command c; bw high selects word-mode unlock addresses
  function automatic fsq_step_t fsq_step(fsq_cmd_t c, logic [2:0] idx, logic bw,
                                         logic [21:0] ta, logic [15:0] td);
    fsq_step_t s;
    logic [21:0] u1;
    logic [21:0] u2;
    u1 = bw ? UA1_W : UA1_B;
    u2 = bw ? UA2_W : UA2_B;
    s  = '{addr: u1, data: D_UNL1, last: 1'b0};
    if (idx == 3'd1 || idx == 3'd4) begin
      s.addr = u2;
      s.data = D_UNL2;
    end
    case (c)
      C_RESET:     s = '{addr: ta, data: D_RESET, last: 1'b1};
      C_SUSPEND:   s = '{addr: ta, data: D_SUSP, last: 1'b1};
      C_SECT_ADD:  s = '{addr: ta, data: D_SECT, last: 1'b1};
      C_BYP_PROG:  s = (idx == 3'd0) ? fsq_step_t'{addr: ta, data: D_PROG, last: 1'b0}
                                     : fsq_step_t'{addr: ta, data: td, last: 1'b1};
      C_BYP_EXIT:  s = (idx == 3'd0) ? fsq_step_t'{addr: ta, data: D_X90, last: 1'b0}
                                     : fsq_step_t'{addr: ta, data: D_X00, last: 1'b1};
      C_PROG:      if (idx == 3'd2) s.data = D_PROG;
                   else if (idx == 3'd3) s = '{addr: ta, data: td, last: 1'b1};
      C_BYP_ENTER: if (idx == 3'd2) s = '{addr: u1, data: D_BYP, last: 1'b1};
      C_SEC_ENTER: if (idx == 3'd2) s = '{addr: u1, data: D_SEC_IN, last: 1'b1};
      C_SEC_EXIT:  if (idx == 3'd2) s.data = D_X90;
                   else if (idx == 3'd3) s = '{addr: ta, data: D_X00, last: 1'b1};
      C_CHIP_ERASE, C_SECT_ERASE: begin
        if (idx == 3'd2) s.data = D_ERASE;
        else if (idx == 3'd5 && c == C_CHIP_ERASE) s = '{addr: u1, data: D_CHIP, last: 1'b1};
        else if (idx == 3'd5) s = '{addr: ta, data: D_SECT, last: 1'b1};
      end
      default:     s.last = 1'b1;
    endcase
    return s;
  endfunction : fsq_step
endpackage : fsq_pkg

//--- verification/fsq_flash_model.sv
/*
  flash device model: logs every write cycle, times its own busy period, answers reads.
  assumes the host launches the flash pins just after a rising hclk edge.
*/
`timescale 1ns/100ps
module fsq_flash_model #(
  parameter int          BUSY_LEN = 100,      // internal algorithm length, arbitrary
  parameter logic [15:0] RD_VAL   = 16'h5A3C  // array data, arbitrary
) (
  input  wire fsq_pkg::fsq_pins_t pins,
  input  wire logic               hclk,
  output logic [15:0]             dq_o,
  output logic                    ready_busy_n
);
  import fsq_pkg::*;
  logic [37:0] wlog [$];  // address and data of each write cycle, busy or not
  logic        we_q;      // strobe seen at the previous edge
  logic [15:0] prev_q;    // data of the previous accepted cycle
  logic        acc_seen;  // high voltage seen while programming
  int          busy;      // cycles left of the internal algorithm
  initial begin
    we_q = 1'b1;
    prev_q = '0;
    acc_seen = 1'b0;
    busy = 0;
    dq_o = '0;
    ready_busy_n = 1'b1;
  end
  // data is taken as the strobe rises; a busy device logs but does not act
  always @(posedge hclk) begin
    we_q <= pins.we_n;
    if (busy > 0) busy = busy - 1;
    if (!pins.reset_n) busy = 0;  // hardware reset stops at once
    else if (pins.we_n && !we_q) begin
      wlog.push_back({pins.addr, pins.dq});
      if (busy == 0) begin  // writes while busy are ignored
        // self-timed program, erase with its own preprogram
        if (prev_q == D_PROG || pins.dq == D_CHIP || pins.dq == D_SECT) busy = BUSY_LEN;
        prev_q <= pins.dq;
      end
    end
    if (pins.accel_hv_en && busy > 0) acc_seen <= 1'b1;  // accelerated program
    ready_busy_n <= (busy == 0);  // progress output
    // a released bus shows a pattern that changes every cycle
    dq_o <= (!pins.ce_n && !pins.oe_n) ? RD_VAL : ~dq_o;
  end
endmodule : fsq_flash_model

//--- verification/fsq_host_chk.sv
/*
  concurrent checks on the flash pins of the sequencer host.
  assumes hclk is the only clock and the flash pins come from flops.
*/
`timescale 1ns/100ps
module fsq_host_chk (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire fsq_pkg::fsq_pins_t flash_pins,
  input wire logic               ready_busy_n
);
  import fsq_pkg::*;
  logic [7:0] rcnt_q;  // edges the flash reset pin has been low
  logic [7:0] rcnt_d;
  // a pulse that is too short may leave the device half reset
  always_comb begin
    rcnt_d = flash_pins.reset_n ? 8'h00 : rcnt_q + 8'h01;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rcnt_q <= 8'h00;
    else rcnt_q <= rcnt_d;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  pin_reset_a: assert property ($rose(hresetn) |-> flash_pins == PINS_RST)
    else $error("flash pins not idle after reset");
  strobe_width_a: assert property ($fell(flash_pins.we_n) |->
    ##1 !flash_pins.we_n ##1 flash_pins.we_n [*2]) else $error("write strobe timing wrong");
  addr_hold_a: assert property ($rose(flash_pins.we_n) |->
    $stable(flash_pins.addr) && $stable(flash_pins.dq) ##1 $stable(flash_pins.addr))
    else $error("address or data moved within a write cycle");
  data_drive_a: assert property (!flash_pins.we_n |->
    flash_pins.dq_oe && !flash_pins.ce_n && flash_pins.oe_n) else $error("strobe without data");
  read_cycle_a: assert property ($fell(flash_pins.oe_n) |->
    !flash_pins.ce_n && !flash_pins.dq_oe ##1 !flash_pins.oe_n ##1 !flash_pins.oe_n)
    else $error("read cycle too short or contended");
  rst_len_a: assert property ($rose(flash_pins.reset_n) |-> rcnt_q == RP_CYC)
    else $error("flash reset pulse length wrong");
  rst_quiet_a: assert property (!flash_pins.reset_n |-> flash_pins.we_n)
    else $error("write during flash reset");
  accel_drop_a: assert property ($fell(flash_pins.accel_hv_en) |->
    ready_busy_n && $past(ready_busy_n)) else $error("high voltage removed while busy");
endmodule : fsq_host_chk
bind fsq_host fsq_host_chk u_chk (.hclk(hclk), .hresetn(hresetn), .flash_pins(flash_pins),
  .ready_busy_n(ready_busy_n));

//--- verification/tb_top.sv
/*
  self-checking bench of the flash sequencer host: ahb master tasks, device model, checks.
  assumes the checker is bound to the design and hready loops back from hreadyout.
*/
`timescale 1ns/100ps
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module tb_top;
  import fsq_pkg::*;
  typedef struct packed {
    logic [3:0]  c;    // order code
    logic [2:0]  n;    // write cycles expected
    logic [15:0] d2;   // data of the third cycle
    logic [15:0] dl;   // data of the last cycle
    logic        t;    // last cycle goes to the target address
    logic        bw;   // word mode
    logic        sec;  // secure region expected after
  } fsq_row_t;
  localparam logic [21:0] TA  = 22'h01_2344;
  localparam logic [15:0] TD  = 16'h1234;
  localparam logic [15:0] RDV = 16'h5A3C;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ready_busy_n;
  logic [31:0] haddr, hwdata, hrdata, st, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] dq_i;
  fsq_pins_t   pins;
  wire logic   hready = hreadyout;  // the one slave drives bus ready
  int          mismatches, check_count, cyc, base;
  fsq_row_t    rows [7] = '{
    '{4'd2, 3'd4, D_PROG, TD, 1'b1, 1'b1, 1'b0}, '{4'd2, 3'd4, D_PROG, TD, 1'b1, 1'b0, 1'b0},
    '{4'd10, 3'd3, D_SEC_IN, D_SEC_IN, 1'b0, 1'b1, 1'b1},
    '{4'd11, 3'd4, D_X90, D_X00, 1'b1, 1'b1, 1'b0},
    '{4'd6, 3'd6, D_ERASE, D_CHIP, 1'b0, 1'b1, 1'b0},
    '{4'd7, 3'd6, D_ERASE, D_SECT, 1'b1, 1'b1, 1'b0},
    '{4'd1, 3'd1, 16'h0000, D_RESET, 1'b1, 1'b1, 1'b0}};
  fsq_host dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_pins(pins), .flash_dq_i(dq_i),
    .ready_busy_n(ready_busy_n));
  fsq_flash_model #(.RD_VAL(RDV)) fm (.hclk(hclk), .pins(pins), .dq_o(dq_i),
    .ready_busy_n(ready_busy_n));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // a hang counts as a mismatch and goes to the verdict
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  // expected write cycle i of a row, worked out from the unlock pattern
  function automatic logic [37:0] exp_step(input fsq_row_t r, input int i);
    logic [21:0] u1;
    logic [21:0] u2;
    u1 = r.bw ? UA1_W : UA1_B;
    u2 = r.bw ? UA2_W : UA2_B;
    if (i == 1 || i == 4) return {u2, D_UNL2};
    if (i == 2) return {u1, r.d2};
    if (i == r.n - 1) return {r.t ? TA : u1, r.dl};
    return {u1, D_UNL1};
  endfunction : exp_step
  // one single transfer; holds each phase until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic status();
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    st = rd;
  endtask : status
  // launch an order, then poll until the sequencer is free
  task automatic order(input logic [31:0] c, input logic [21:0] a, input logic [15:0] d);
    int n;
    n = 0;
    bus(1'b1, OFS_ADDR, {10'h000, a});
    bus(1'b1, OFS_WDATA, {16'h0000, d});
    bus(1'b1, OFS_CTRL, c);
    do begin
      status();
      n++;
    end while (st[ST_CTL_BUSY] !== 1'b0 && n < 100);
    `CHK("order end", 1'b0, st[ST_CTL_BUSY])
  endtask : order
  // wait for the flash ready and the erase window closed
  task automatic settle();
    int n;
    n = 0;
    do begin
      status();
      n++;
    end while ((st[ST_RDY] !== 1'b1 || st[ST_WIN] !== 1'b0) && n < 2000);
    `CHK("settled", 2'b10, {st[ST_RDY], st[ST_WIN]})
  endtask : settle
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    {mismatches, check_count, cyc} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFS_CTRL, 32'h0000_0000);
    `CHK("ctrl reset", CTRL_RST, rd)
    `CHK("bus answer", 2'b10, {hreadyout, hresp})
    bus(1'b0, 8'h10, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    status();
    `CHK("status reset", 7'h02, st[6:0])
    done("reset");
    foreach (rows[k]) begin
      base = fm.wlog.size();
      order({23'h00_0000, rows[k].bw, 4'h0, rows[k].c}, TA, TD);
      settle();
      `CHK("cycles", base + int'(rows[k].n), fm.wlog.size())
      for (int i = 0; i < rows[k].n; i++)
        `CHK("cycle", exp_step(rows[k], i), fm.wlog[base + i])
      `CHK("secure", rows[k].sec, st[ST_SEC])
    end
    done("table");
    base = fm.wlog.size();
    order(32'h0000_0104, TA, TD);
    `CHK("refused", 1'b1, st[ST_ERR])
    `CHK("no cycles", base, fm.wlog.size())
    order(32'h0000_0103, TA, TD);
    settle();
    `CHK("bypass on", 1'b1, st[ST_BYP])
    base = fm.wlog.size();
    order(32'h0000_0102, TA, TD);
    `CHK("bypass refuse", base, fm.wlog.size())
    order(32'h0000_0104, TA, TD);
    settle();
    `CHK("bp set-up", {TA, D_PROG}, fm.wlog[base])
    `CHK("bp data", {TA, TD}, fm.wlog[base + 1])
    order(32'h0000_0105, TA, TD);
    settle();
    `CHK("exit 1", {TA, D_X90}, fm.wlog[base + 2])
    `CHK("exit 2", D_X00, fm.wlog[base + 3][15:0])
    `CHK("bypass off", 1'b0, st[ST_BYP])
    done("bypass");
    base = fm.wlog.size();
    order(32'h0000_0304, TA, TD);
    settle();
    `CHK("acc cycles", base + 2, fm.wlog.size())
    `CHK("acc used", 1'b1, fm.acc_seen)
    `CHK("acc off", 1'b0, pins.accel_hv_en)
    done("accel");
    order(32'h0000_0107, TA, TD);
    `CHK("window open", 1'b1, st[ST_WIN])
    base = fm.wlog.size();
    order(32'h0000_0108, 22'h02_0000, TD);
    settle();
    `CHK("added sector", {22'h02_0000, D_SECT}, fm.wlog[base])
    `CHK("window shut", 1'b0, st[ST_WIN])
    done("sector window");
    order(32'h0000_0107, TA, TD);
    base = fm.wlog.size();
    order(32'h0000_0109, TA, TD);
    `CHK("suspend", {TA, D_SUSP}, fm.wlog[base])
    `CHK("suspend shut", 1'b0, st[ST_WIN])
    `CHK("suspend op", 2'b00, st[9:8])
    settle();
    done("suspend");
    order(32'h0000_0102, TA, TD);
    bus(1'b1, OFS_STATUS, 32'h0000_0020);
    base = fm.wlog.size();
    order(32'h0000_010A, TA, TD);
    `CHK("secure busy", 1'b1, st[ST_ERR])
    `CHK("busy quiet", base, fm.wlog.size())
    order(32'h0000_0109, TA, TD);
    `CHK("no suspend", base, fm.wlog.size())
    settle();
    order(32'h0000_0106, TA, TD);
    order(32'h0000_010C, TA, TD);
    `CHK("erase aborted", 1'b1, ready_busy_n)
    settle();
    order(32'h0000_0100, TA, TD);
    `CHK("array read", RDV, st[31:16])
    done("busy and reset");
    print_verdict();
  end
endmodule : tb_top
